// file: hdl/kpi_defs.svh
// constants for the keypad pin interrupt unit: offsets, fields, reset values
// assumes inclusion from kpi_pkg users; definitions only
//
// Notes on behaviour
// - eight input pins feed one shared keypad event flag
// - enable bit 1 makes its pin a source; 0 excludes it
// - polarity bit 0 means falling/low, 1 means rising/high
// - one mode bit selects edge only or edge plus level for all
// - edges found by clocked sampling; deasserted level must be seen first
// - falling edge: sampled 1 then 0 on the next cycle
// - rising edge: sampled 0 then 1 on the next cycle
// - in edge mode a valid edge on an enabled pin sets the flag
// - flag and irq enable together raise the interrupt request
// - in edge mode writing acknowledge 1 clears the flag
// - in level mode an edge or asserted level sets the flag
// - in level mode acknowledge clears only if all enabled pins deasserted
// - enabled pull is pullup for polarity 0, pulldown for polarity 1
// - flag at status bit 3, read only
// - acknowledge at bit 2 acts on write 1, reads 0
// - bit 1 irq enable, bit 0 mode, bits 7:4 read 0
`ifndef KPI_DEFS_SVH
`define KPI_DEFS_SVH
`define KPI_OFS_STATUS   12'h000
`define KPI_OFS_ENABLE   12'h004
`define KPI_OFS_POLARITY 12'h008
`define KPI_BIT_FLAG     3
`define KPI_BIT_ACK      2
`define KPI_BIT_IRQEN    1
`define KPI_BIT_MODE     0
`define KPI_RST_BYTE     8'h00
`endif

// file: hdl/kpi_detect.sv
// per-pin edge and level detection for the keypad pin interrupt unit
// assumes pins already synchronised to clk
`timescale 1ns/10ps
`include "kpi_defs.svh"
module kpi_detect
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  // configuration
  input  wire kpi_pkg::kpi_byte_t pin_source_enable,
  input  wire kpi_pkg::kpi_byte_t pin_polarity_select,
  // synchronised pins
  input  wire kpi_pkg::kpi_byte_t pins_sync,
  // results
  output kpi_pkg::kpi_byte_t    edge_hit,
  output kpi_pkg::kpi_byte_t    level_hit
);
  import kpi_pkg::*;
  typedef struct packed {
    kpi_byte_t armed;
  } kpi_det_s;
  kpi_det_s st_q;
  kpi_det_s st_d;
  kpi_byte_t asserted;

  // polarity maps each pin to its asserted sense
  always_comb
  begin
    asserted  = ~(pins_sync ^ pin_polarity_select);
    level_hit = asserted & pin_source_enable;
    // armed means deasserted last cycle, so edge needs 1->0 or 0->1
    edge_hit  = st_q.armed & asserted & pin_source_enable;
    st_d.armed = ~asserted & pin_source_enable;
  end

  // disabled pins lose arming so a fresh enable needs a deasserted sample
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st_q <= '0;
    else if (clk_en)
      st_q <= st_d;
  end

  a_edge_needs_idle : assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && $past(clk_en) && |edge_hit) |-> (edge_hit & $past(asserted)) == 8'h00)
    else $error("edge without idle sample");
endmodule

// file: hdl/kpi_pkg.sv
// types for the keypad pin interrupt unit
// assumes kpi_defs.svh for numeric constants
package kpi_pkg;
  typedef logic [7:0] kpi_byte_t;
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } kpi_apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } kpi_apb_rsp_s;
endpackage

// file: hdl/kpi_top.sv
// keypad pin interrupt unit: apb registers, flag and request logic
// assumes pins asynchronous to clk, apb master on clk
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "kpi_defs.svh"
module kpi_top
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  // apb slave
  input  wire kpi_pkg::kpi_apb_req_s apb_req,
  output kpi_pkg::kpi_apb_rsp_s apb_rsp,
  // keypad pins and pull control
  input  wire kpi_pkg::kpi_byte_t keypad_input_pin,
  input  wire kpi_pkg::kpi_byte_t port_pull_enable,
  output kpi_pkg::kpi_byte_t    pull_up_en,
  output kpi_pkg::kpi_byte_t    pull_down_en,
  // interrupt request
  output logic                  keypad_irq
);
  import kpi_pkg::*;

  typedef struct packed {
    kpi_byte_t   sync1;
    kpi_byte_t   sync2;
    kpi_byte_t   pin_source_enable;
    kpi_byte_t   pin_polarity_select;
    logic        keypad_event_flag;
    logic        keypad_irq_enable;
    logic        detect_mode_select;
    logic [31:0] rdata;
    kpi_byte_t   pull_up;
    kpi_byte_t   pull_down;
    logic        irq;
  } kpi_state_s;

  kpi_state_s st_q;
  kpi_state_s st_d;
  kpi_byte_t  edge_hit;
  kpi_byte_t  level_hit;
  logic       acc;
  logic       wr;
  logic       ack;
  logic       set_ev;

  function automatic logic [7:0] kpi_status_read(input logic f, input logic ie,
                                                 input logic md);
    logic [7:0] v;
    v = 8'h00;
    v[`KPI_BIT_FLAG]  = f;
    v[`KPI_BIT_IRQEN] = ie;
    v[`KPI_BIT_MODE]  = md;                                    // ack reads 0
    return v;
  endfunction

  kpi_detect u_det
  (
    .clk                 (clk),
    .resetn              (resetn),
    .clk_en              (clk_en),
    .pin_source_enable   (st_q.pin_source_enable),
    .pin_polarity_select (st_q.pin_polarity_select),
    .pins_sync           (st_q.sync2),
    .edge_hit            (edge_hit),
    .level_hit           (level_hit)
  );

  // zero-wait slave while clk_en is high: access phase completes in its first cycle
  assign acc = apb_req.psel & apb_req.penable;
  assign wr  = acc & apb_req.pwrite;
  assign ack = wr && apb_req.paddr == `KPI_OFS_STATUS && apb_req.pwdata[`KPI_BIT_ACK];
  // no transfer completes while frozen, so a write is never lost
  assign apb_rsp.pready  = clk_en;
  assign apb_rsp.pslverr = 1'b0;
  assign apb_rsp.prdata  = st_q.rdata;
  assign pull_up_en      = st_q.pull_up;
  assign pull_down_en    = st_q.pull_down;
  assign keypad_irq      = st_q.irq;

  // set takes priority over acknowledge so no event is lost
  always_comb
  begin
    st_d = st_q;
    st_d.sync1 = keypad_input_pin;
    st_d.sync2 = st_q.sync1;
    set_ev = st_q.detect_mode_select ? |(edge_hit | level_hit)
                                     : |edge_hit;
    if (ack)
      st_d.keypad_event_flag = 1'b0;
    if (set_ev)
      st_d.keypad_event_flag = 1'b1;
    if (wr)
    begin
      unique case (apb_req.paddr)
        `KPI_OFS_STATUS:
        begin
          st_d.keypad_irq_enable  = apb_req.pwdata[`KPI_BIT_IRQEN];
          st_d.detect_mode_select = apb_req.pwdata[`KPI_BIT_MODE];
        end
        `KPI_OFS_ENABLE:   st_d.pin_source_enable   = apb_req.pwdata[7:0];
        `KPI_OFS_POLARITY: st_d.pin_polarity_select = apb_req.pwdata[7:0];
        default: ;
      endcase
    end
    // read data registered at setup so it is stable in access phase
    st_d.rdata = 32'h0000_0000;
    if (apb_req.psel && !apb_req.pwrite)
    begin
      unique case (apb_req.paddr)
        `KPI_OFS_STATUS:   st_d.rdata[7:0] = kpi_status_read(st_q.keypad_event_flag,
                             st_q.keypad_irq_enable, st_q.detect_mode_select);
        `KPI_OFS_ENABLE:   st_d.rdata[7:0] = st_q.pin_source_enable;
        `KPI_OFS_POLARITY: st_d.rdata[7:0] = st_q.pin_polarity_select;
        default:           st_d.rdata      = 32'h0000_0000;
      endcase
    end
    st_d.pull_up   = port_pull_enable & ~st_q.pin_polarity_select;
    st_d.pull_down = port_pull_enable & st_q.pin_polarity_select;
    st_d.irq = st_q.keypad_event_flag & st_q.keypad_irq_enable;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= '0;
      st_q.pin_source_enable   <= `KPI_RST_BYTE;
      st_q.pin_polarity_select <= `KPI_RST_BYTE;
    end
    else if (clk_en)
      st_q <= st_d;
  end

  a_irq_follows : assert property (@(posedge clk) disable iff (!resetn)
    clk_en |=> keypad_irq == ($past(st_q.keypad_event_flag) && $past(st_q.keypad_irq_enable)))
    else $error("irq not flag and enable");
  a_edge_sets_flag : assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && |edge_hit) |=> st_q.keypad_event_flag)
    else $error("edge did not set flag");
  a_level_holds_flag : assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && st_q.detect_mode_select && |level_hit) |=> st_q.keypad_event_flag)
    else $error("level did not hold flag");
  a_ack_clears : assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && ack && !set_ev) |=> !st_q.keypad_event_flag)
    else $error("ack did not clear");
  a_no_spurious : assert property (@(posedge clk) disable iff (!resetn)
    (clk_en && !set_ev && !st_q.keypad_event_flag) |=> !st_q.keypad_event_flag)
    else $error("flag set without cause");
  a_pull_split : assert property (@(posedge clk) disable iff (!resetn)
    (pull_up_en & pull_down_en) == 8'h00)
    else $error("pull up and down together");
  a_upper_zero : assert property (@(posedge clk) disable iff (!resetn)
    apb_rsp.prdata[31:8] == 24'h000000 &&
    (!(acc && !apb_req.pwrite && apb_req.paddr == `KPI_OFS_STATUS) ||
     apb_rsp.prdata[7:4] == 4'h0))
    else $error("upper read bits set");
  a_ack_reads_zero : assert property (@(posedge clk) disable iff (!resetn)
    (acc && !apb_req.pwrite && apb_req.paddr == `KPI_OFS_STATUS) |-> !apb_rsp.prdata[2])
    else $error("ack reads one");
endmodule

// file: testbench/keypad_pin_interrupt_tb.sv
// self-checking bench for the keypad pin interrupt unit
// assumes kpi_top on a 50 ns clock and the keypad model on its pins
`timescale 1ns/10ps
`include "kpi_defs.svh"
module keypad_pin_interrupt_tb;
  import kpi_pkg::*;
  logic         clk = 0;
  logic         resetn = 0;
  kpi_apb_req_s req = '0;
  kpi_apb_rsp_s rsp;
  kpi_byte_t    lvl = '0, flt = '0, ppe = '0, pol, en, pu, pd, pins;
  logic         irq, ie = 0, md = 0, m_flag = 0, cen = 1;
  logic [31:0]  rd;
  int           n_mismatch = 0, samples_checked = 0;

  kpi_top i_dut (.clk(clk), .resetn(resetn), .clk_en(cen), .apb_req(req), .apb_rsp(rsp),
                 .keypad_input_pin(pins), .port_pull_enable(ppe), .pull_up_en(pu),
                 .pull_down_en(pd), .keypad_irq(irq));
  kpi_keypad_model i_keys (.clk(clk), .lvl(lvl), .flt(flt), .pu(pu), .pd(pd), .pins(pins));

  initial
    forever #25 clk = ~clk;

  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task final_report;
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one apb transfer; read data taken at the edge that sees pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    rd = rsp.prdata;
    req <= '0;
    if (n >= 20)
    begin
      n_mismatch++;
      final_report();
    end
  endtask

  task ctl(input logic ack);
    apb(1'b1, `KPI_OFS_STATUS, {29'h0, ack, ie, md});
  endtask

  // status read and request line against the model flag
  task check_flag;
    apb(1'b0, `KPI_OFS_STATUS, 32'h0);
    chk(rd, {28'h0, m_flag, 1'b0, ie, md});
    chk({31'h0, irq}, {31'h0, m_flag & ie});
    chk({31'h0, rsp.pslverr}, 32'h0);
  endtask

  initial
  begin
    void'($urandom(32'hd5ce));
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    // reset values, then one unmapped word
    for (int a = 0; a < 16; a += 4)
    begin
      apb(1'b0, a[11:0], 32'h0);
      chk(rd, 32'h0);
    end
    // flag is not writable, ack and upper bits read zero
    apb(1'b1, `KPI_OFS_STATUS, 32'hFF);
    ie = 1;
    md = 1;
    check_flag();
    for (int k = 0; k < 16; k++)
    begin
      // init order: mask, polarity, pins idle, enables, then ack and unmask in one write
      md = k[3];
      ie = 0;
      ctl(1'b0);
      pol = 8'($urandom);
      en = 8'($urandom);
      ppe <= 8'($urandom) | (8'h01 << k[2:0]);
      apb(1'b1, `KPI_OFS_POLARITY, {24'h0, pol});
      lvl <= ~pol;
      flt <= 8'h00;
      apb(1'b1, `KPI_OFS_ENABLE, {24'h0, en});
      repeat (4) @(posedge clk);
      // freeze a few cycles between transfers: state must hold, no bus access is made while frozen
      cen <= 1'b0;
      repeat (1 + $urandom % 3) @(posedge clk);
      cen <= 1'b1;
      ie = 1;
      ctl(1'b1);
      m_flag = 0;
      check_flag();
      chk({24'h0, pu}, {24'h0, ppe & ~pol});
      chk({24'h0, pd}, {24'h0, ppe & pol});
      // assert one pin: flag only if that pin is enabled
      lvl[k[2:0]] <= pol[k[2:0]];
      repeat (5) @(posedge clk);
      m_flag = en[k[2:0]];
      check_flag();
      // ack while held: edge mode clears, level mode keeps it
      ctl(1'b1);
      m_flag = md & en[k[2:0]];
      check_flag();
      // release to the pull, which is the idle level
      flt[k[2:0]] <= 1'b1;
      repeat (5) @(posedge clk);
      ctl(1'b1);
      m_flag = 0;
      check_flag();
    end
    final_report();
  end
endmodule

// file: testbench/kpi_keypad_model.sv
// keypad switch model: drives the pins, released pins settle to their pull
// assumes pull controls come from the unit under test
`timescale 1ns/10ps
module kpi_keypad_model
(
  // clock
  input  wire logic               clk,
  // bench levels, release mask and pulls
  input  wire kpi_pkg::kpi_byte_t lvl,
  input  wire kpi_pkg::kpi_byte_t flt,
  input  wire kpi_pkg::kpi_byte_t pu,
  input  wire kpi_pkg::kpi_byte_t pd,
  // pins
  output kpi_pkg::kpi_byte_t      pins
);
  import kpi_pkg::*;
  kpi_byte_t last_q;
  // unpulled released pins flip, so a stale level never looks valid
  always_comb pins = (~flt & lvl) | (flt & pu) | (flt & ~pu & ~pd & ~last_q);
  always_ff @(posedge clk) last_q <= pins;
endmodule
